// ===== hdl/csw_clock_switch.sv
/*
  Clock switch controller with APB registers, start-up timer and fail monitor.
  Assumes oscillator ready and lock levels and the clock pins are asynchronous;
  sleep, wake and doze come from logic on clk_sys.
*/
//
// Behaviour
// - Keep running on present clock until requested source reports ready.
// - Divider-only change or already-running source counts as ready at once.
// - On ready, set new-source-ready and switch interrupt flag.
// - Raise switch interrupt when its flag sets and its enable is one.
// - With hold clear, switch as soon as new-source-ready sets.
// - With hold set, wait; software clears hold or copies current to abandon.
// - Under doze the pending switch completes on the next clock cycle.
// - Divider-only change uses the same handshake; completes only with hold zero.
// - Current fields keep old values until switch; then ready sets, new-ready clears.
// - PLL input follows request when PLL requested from a non-PLL source or while relocking, otherwise current source.
// - PLL input change: run on current, then halt while PLL relocks.
// - PLL not locking after input change triggers the fail-safe response.
// - Sleep before switch completes cancels the switch and enters sleep.
// - Wake with hold clear resumes on new clock and sets switch flag.
// - Wake with hold set resumes on old clock and requests again.
// - Fail monitor runs only when enabled, on all external sources.
// - Sample clock is the slow internal oscillator divided by 64.
// - Latch set by external fall, cleared by sample rise; fail on silent half.
// - On failure fall back to fast internal 1 MHz and set fail flag.
// - Stay on internal clock after fallback until software writes a new request.
// - Fail condition clears on reset, sleep, or a changing request write.
// - Switching to ext or ext PLL restarts start-up timer; monitor waits for it again.
// - Start-up timer counts 1024 oscillator cycles after reset or wake.
// - Source codes: 7 ext, 6 fast, 5 slow, 4 sec, 2 ext PLL, 1 fast PLL.
// - Request write with reserved source code is discarded entirely.
`timescale 1ns/1ps
`include "csw_cfg.svh"
module csw_clock_switch (
  input logic clk_sys,
  input logic rstn,
  input logic [7:0] paddr,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic external_osc,
  input logic secOsc,
  input logic slowOsc,
  input logic fastReady,
  input logic secReady,
  input logic pllLock,
  input logic failsafeEnable,
  input logic dozeActive,
  input logic sleepEnter,
  input logic wakeUp,
  output csw_pkg::csw_src_t sysSource,
  output csw_pkg::csw_div_t sysDivider,
  output logic clkGateEn,
  output logic cpuHalt,
  output logic pllInputExt,
  output logic sleeping,
  output logic switchIrq,
  output logic failIrq
);
  import csw_pkg::*;
  csw_state_t state;
  csw_src_t reqSrc, curSrc, tgtSrc;
  csw_div_t reqDiv, curDiv, tgtDiv;
  logic hold, oscReady, newReady, swFlag, failFlag, swEn, failEn;
  logic failCond, failSwitch;
  logic [1:0] gateCnt;
  logic [7:0] lockCnt;
  wire [2:0] stat;
  logic [2:0] statPin;
  logic srcRdy, newRdy, pending, pllInChg;
  logic apbAcc, apbWr, reqWr, reqChg;
  logic waitHit, wakeCommit, swSet, lockFail, failGo;
  logic [7:0] rd8;

  csw_osc_if osc();

  csw_startup_timer u_ost (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .external_osc(external_osc),
    .osc(osc.startup_timer)
  );

  csw_fail_detect u_mon (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .external_osc(external_osc),
    .secOsc(secOsc),
    .slowOsc(slowOsc),
    .osc(osc.mon)
  );

  //****************************************
  // decoding
  //****************************************
  function automatic logic isPll(input csw_src_t s);
    return s == `CSW_SRC_EXT_PLL || s == `CSW_SRC_FAST_PLL;
  endfunction

  function automatic logic isExt(input csw_src_t s);
    return s == `CSW_SRC_EXT || s == `CSW_SRC_EXT_PLL || s == `CSW_SRC_SEC;
  endfunction

  function automatic logic isRsv(input csw_src_t s);
    return s == `CSW_SRC_RSV_HI || s == `CSW_SRC_RSV_LO;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == `CSW_REQ_OFS || a == `CSW_CUR_OFS || a == `CSW_CTL_OFS ||
      a == `CSW_FLG_OFS || a == `CSW_IEN_OFS;
  endfunction

  //****************************************
  // status synchronisers
  //****************************************
  assign statPin = {pllLock, secReady, fastReady};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_sync
      logic s1, s2, s3, lvl;
      always_ff @(posedge clk_sys)
      begin
        s1 <= statPin[gi];
        s2 <= s1;
        s3 <= s2;
      end
      always_ff @(posedge clk_sys)
      begin
        if (!rstn)
          lvl <= 1'h0;
        else if (s2 == s3)
          lvl <= s2;
      end
      assign stat[gi] = lvl;
    end
  endgenerate

  //****************************************
  // readiness and switch events
  //****************************************
  always_comb
  begin
    case (reqSrc)
      `CSW_SRC_EXT: srcRdy = osc.ostDone;
      `CSW_SRC_EXT_PLL: srcRdy = osc.ostDone && (pllInChg || stat[2]);
      `CSW_SRC_FAST: srcRdy = stat[0];
      `CSW_SRC_FAST_PLL: srcRdy = stat[0] && (pllInChg || stat[2]);
      `CSW_SRC_SLOW: srcRdy = 1'h1;
      `CSW_SRC_SEC: srcRdy = stat[1];
      default: srcRdy = 1'h0;
    endcase
  end

  assign newRdy = srcRdy || reqSrc == curSrc;
  assign pending = {reqSrc, reqDiv} != {curSrc, curDiv};
  assign pllInChg = isPll(reqSrc) && isPll(curSrc) && reqSrc != curSrc;
  assign waitHit = state == ST_WAIT && pending && newRdy;
  assign wakeCommit = state == ST_SLEEP && wakeUp && pending && !hold;
  // sleep or fallback in the same cycle means no switch, so no flag
  assign swSet = !sleepEnter && !failGo && (waitHit || wakeCommit);
  assign lockFail = state == ST_RELOCK && !stat[2] &&
    lockCnt == 8'(`CSW_LOCK_CYC - 1);
  assign failGo = !sleepEnter && (osc.failPulse || lockFail);

  //****************************************
  // APB slave
  //****************************************
  assign apbAcc = psel && penable;
  assign apbWr = apbAcc && pwrite;
  assign pready = 1'h1;
  assign pslverr = apbAcc && !mapped(paddr);
  assign reqWr = apbWr && paddr == `CSW_REQ_OFS && !isRsv(pwdata[6:4]);
  assign reqChg = reqWr && pwdata[6:0] != {reqSrc, reqDiv};

  always_comb
  begin
    rd8 = 8'h00;
    case (paddr)
      `CSW_REQ_OFS: rd8 = {1'h0, reqSrc, reqDiv};
      `CSW_CUR_OFS: rd8 = {1'h0, curSrc, curDiv};
      `CSW_CTL_OFS:
      begin
        rd8[`CSW_HOLD_BIT] = hold;
        rd8[`CSW_OSCILLATOR_READY_BIT] = oscReady;
        rd8[`CSW_NSR_BIT] = newReady;
        rd8[`CSW_FCOND_BIT] = failCond;
      end
      `CSW_FLG_OFS:
      begin
        rd8[`CSW_SWIF_BIT] = swFlag;
        rd8[`CSW_OFIF_BIT] = failFlag;
      end
      `CSW_IEN_OFS:
      begin
        rd8[`CSW_SWIF_BIT] = swEn;
        rd8[`CSW_OFIF_BIT] = failEn;
      end
      default: rd8 = 8'h00;
    endcase
  end

  // read data captured in the setup cycle, valid through the access phase
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable)
      prdata <= {24'h00_0000, rd8};
  end

  //****************************************
  // request, hold and enables
  //****************************************
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      reqSrc <= `CSW_RST_SRC;
      reqDiv <= `CSW_RST_DIV;
    end
    else if (failGo)
    begin
      reqSrc <= `CSW_SRC_FAST;
      reqDiv <= `CSW_RST_DIV;
    end
    else if (reqWr)
    begin
      reqSrc <= pwdata[6:4];
      reqDiv <= pwdata[3:0];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      hold <= 1'h0;
      swEn <= 1'h0;
      failEn <= 1'h0;
    end
    else if (apbWr && paddr == `CSW_CTL_OFS)
      hold <= pwdata[`CSW_HOLD_BIT];
    else if (apbWr && paddr == `CSW_IEN_OFS)
    begin
      swEn <= pwdata[`CSW_SWIF_BIT];
      failEn <= pwdata[`CSW_OFIF_BIT];
    end
  end

  //****************************************
  // flags, write one to clear, set wins
  //****************************************
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      swFlag <= 1'h0;
      failFlag <= 1'h0;
    end
    else
    begin
      if (swSet)
        swFlag <= 1'h1;
      else if (apbWr && paddr == `CSW_FLG_OFS && pwdata[`CSW_SWIF_BIT])
        swFlag <= 1'h0;
      if (failGo)
        failFlag <= 1'h1;
      else if (apbWr && paddr == `CSW_FLG_OFS && pwdata[`CSW_OFIF_BIT])
        failFlag <= 1'h0;
    end
  end

  assign switchIrq = swFlag && swEn;
  assign failIrq = failFlag && failEn;

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      failCond <= 1'h0;
    else if (failGo)
      failCond <= 1'h1;
    else if (sleepEnter || reqChg)
      failCond <= 1'h0;
  end

  //****************************************
  // switch sequencer
  //****************************************
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      state <= ST_IDLE;
      curSrc <= `CSW_RST_SRC;
      curDiv <= `CSW_RST_DIV;
      tgtSrc <= `CSW_RST_SRC;
      tgtDiv <= `CSW_RST_DIV;
      newReady <= 1'h0;
      oscReady <= 1'h1;
      gateCnt <= 2'h0;
      lockCnt <= 8'h00;
      failSwitch <= 1'h0;
    end
    else if (sleepEnter)
    begin
      state <= ST_SLEEP;
      newReady <= 1'h0;
    end
    else if (failGo)
    begin
      tgtSrc <= `CSW_SRC_FAST;
      tgtDiv <= `CSW_RST_DIV;
      failSwitch <= 1'h1;
      newReady <= 1'h0;
      gateCnt <= 2'h0;
      state <= ST_GATE;
    end
    else
    begin
      case (state)
        ST_IDLE:
          if (pending)
          begin
            oscReady <= 1'h0;
            state <= ST_WAIT;
          end
        ST_WAIT:
          if (!pending)
          begin
            oscReady <= 1'h1;
            state <= ST_IDLE;
          end
          else if (newRdy)
          begin
            newReady <= 1'h1;
            tgtSrc <= reqSrc;
            tgtDiv <= reqDiv;
            gateCnt <= 2'h0;
            lockCnt <= 8'h00;
            if (hold)
              state <= ST_READY;
            else
              state <= pllInChg ? ST_RELOCK : ST_GATE;
          end
        ST_READY:
          if (!pending)
          begin
            newReady <= 1'h0;
            oscReady <= 1'h1;
            state <= ST_IDLE;
          end
          else if ({reqSrc, reqDiv} != {tgtSrc, tgtDiv})
          begin
            newReady <= 1'h0;
            state <= ST_WAIT;
          end
          else if (!hold)
            state <= pllInChg ? ST_RELOCK : ST_GATE;
        ST_RELOCK:
          if (stat[2] && lockCnt >= 8'(`CSW_GATE_CYC))
          begin
            gateCnt <= 2'h0;
            state <= ST_GATE;
          end
          else
            lockCnt <= lockCnt + 8'h01;
        ST_GATE:
          // doze does not wait for the core, only for the gate
          if (dozeActive || gateCnt == 2'(`CSW_GATE_CYC - 1))
          begin
            curSrc <= tgtSrc;
            curDiv <= tgtDiv;
            oscReady <= 1'h1;
            newReady <= 1'h0;
            failSwitch <= 1'h0;
            state <= ST_IDLE;
          end
          else
            gateCnt <= gateCnt + 2'h1;
        ST_SLEEP:
          if (wakeUp)
          begin
            if (wakeCommit)
            begin
              curSrc <= reqSrc;
              curDiv <= reqDiv;
              oscReady <= 1'h1;
              state <= ST_IDLE;
            end
            else if (pending)
              state <= ST_WAIT;
            else
              state <= ST_IDLE;
          end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  //****************************************
  // clock tree controls
  //****************************************
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      pllInputExt <= 1'h0;
    else if (isPll(reqSrc) && (state == ST_RELOCK || (pending && !isPll(curSrc))))
      pllInputExt <= reqSrc == `CSW_SRC_EXT_PLL;
    else
      pllInputExt <= curSrc == `CSW_SRC_EXT_PLL;
  end

  // gate held low around the select change so no runt pulse escapes
  assign clkGateEn = state != ST_GATE;
  assign cpuHalt = state == ST_RELOCK;
  assign sleeping = state == ST_SLEEP;
  assign sysSource = curSrc;
  assign sysDivider = curDiv;
  assign osc.ostRestart = (state == ST_IDLE && pending && reqSrc != curSrc &&
    (reqSrc == `CSW_SRC_EXT || reqSrc == `CSW_SRC_EXT_PLL)) ||
    (state == ST_SLEEP && wakeUp);
  assign osc.monEnable = failsafeEnable && isExt(curSrc) && state != ST_SLEEP &&
    (curSrc == `CSW_SRC_SEC || osc.ostDone);
  assign osc.monSec = curSrc == `CSW_SRC_SEC;

  //****************************************
  // assertions
  //****************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  sequence s_fast_ready;
    waitHit && !hold && !pllInChg && !sleepEnter && !failGo;
  endsequence
  sequence s_quiet2;
    (!sleepEnter && !failGo)[*2];
  endsequence

  property p_wait_keeps;
    state == ST_WAIT && !failGo |=> $stable(curSrc) && $stable(curDiv);
  endproperty
  a_wait_keeps: assert property (p_wait_keeps) else $error("clock moved while waiting");

  property p_same_src;
    state == ST_WAIT && pending && reqSrc == curSrc && !sleepEnter && !failGo |=> newReady;
  endproperty
  a_same_src: assert property (p_same_src) else $error("same source not ready");

  property p_flag_with_ready;
    $rose(newReady) |-> swFlag;
  endproperty
  a_flag_with_ready: assert property (p_flag_with_ready) else $error("flag missing");

  property p_irq;
    $rose(swFlag) && swEn |-> switchIrq;
  endproperty
  a_irq: assert property (p_irq) else $error("switch irq missing");

  property p_no_hold_switch;
    s_fast_ready ##1 s_quiet2 |=> oscReady && curSrc == $past(reqSrc, 3);
  endproperty
  a_no_hold_switch: assert property (p_no_hold_switch) else $error("switch late");

  property p_hold_keeps;
    state == ST_READY && hold && !failGo |=> $stable(curSrc) && $stable(curDiv);
  endproperty
  a_hold_keeps: assert property (p_hold_keeps) else $error("switched on hold");

  property p_doze;
    state == ST_GATE && dozeActive && !sleepEnter && !failGo |=> state == ST_IDLE;
  endproperty
  a_doze: assert property (p_doze) else $error("doze switch late");

  property p_commit;
    $changed(curSrc) |-> oscReady && !newReady;
  endproperty
  a_commit: assert property (p_commit) else $error("status not updated");

  property p_lock_fail;
    lockFail |=> state == ST_GATE && failSwitch && failFlag;
  endproperty
  a_lock_fail: assert property (p_lock_fail) else $error("no fallback on lock");

  property p_sleep;
    sleepEnter |=> state == ST_SLEEP && !newReady && $stable(curSrc);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep did not cancel");

  property p_wake;
    wakeCommit && !sleepEnter |=> curSrc == $past(reqSrc) && swFlag;
  endproperty
  a_wake: assert property (p_wake) else $error("wake not on new clock");

  property p_rsv;
    apbWr && paddr == `CSW_REQ_OFS && isRsv(pwdata[6:4]) && !failGo
      |=> $stable(reqSrc) && $stable(reqDiv);
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved code taken");
endmodule // csw_clock_switch

// ===== hdl/csw_cfg.svh
/*
  Offsets, field positions, reset values and timing counts of the clock switch.
  Assumes inclusion by every design file that decodes registers or counts time.
*/
`ifndef CSW_CFG_SVH
`define CSW_CFG_SVH
`define CSW_REQ_OFS 8'h00
`define CSW_CUR_OFS 8'h04
`define CSW_CTL_OFS 8'h08
`define CSW_FLG_OFS 8'h0C
`define CSW_IEN_OFS 8'h10
`define CSW_HOLD_BIT 7
`define CSW_OSCILLATOR_READY_BIT 4
`define CSW_NSR_BIT 3
`define CSW_FCOND_BIT 0
`define CSW_SWIF_BIT 0
`define CSW_OFIF_BIT 1
`define CSW_SRC_EXT 3'h7
`define CSW_SRC_FAST 3'h6
`define CSW_SRC_SLOW 3'h5
`define CSW_SRC_SEC 3'h4
`define CSW_SRC_RSV_HI 3'h3
`define CSW_SRC_EXT_PLL 3'h2
`define CSW_SRC_FAST_PLL 3'h1
`define CSW_SRC_RSV_LO 3'h0
`define CSW_RST_SRC 3'h6
`define CSW_RST_DIV 4'h2
`define CSW_OST_CNT 11'h400
`define CSW_FS_MSB 5
`define CSW_CLK_NS 50
`define CSW_LOCK_NS 2000
`define CSW_LOCK_CYC ((`CSW_LOCK_NS) / (`CSW_CLK_NS))
`define CSW_GATE_CYC 2
`endif

// ===== hdl/csw_pkg.sv
/*
  Types of the clock switch: controller states, source and divider codes.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package csw_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_WAIT = 3'h1,
    ST_READY = 3'h2,
    ST_GATE = 3'h3,
    ST_RELOCK = 3'h4,
    ST_SLEEP = 3'h5
  } csw_state_t;
  typedef logic [2:0] csw_src_t;
  typedef logic [3:0] csw_div_t;
endpackage

// ===== hdl/csw_osc_if.sv
/*
  Carrier between the switch controller, the start-up timer and the monitor.
  Assumes all three sit on clk_sys.
*/
`timescale 1ns/1ps
interface csw_osc_if;
  logic ostRestart;
  logic ostDone;
  logic monEnable;
  logic monSec;
  logic failPulse;
  modport ctl(output ostRestart, output monEnable, output monSec,
    input ostDone, input failPulse);
  modport startup_timer(input ostRestart, output ostDone);
  modport mon(input monEnable, input monSec, output failPulse);
endinterface

// ===== hdl/csw_startup_timer.sv
/*
  Start-up timer: counts external oscillator periods after a restart.
  Assumes external_osc is an asynchronous pin far slower than clk_sys.
*/
`timescale 1ns/1ps
`include "csw_cfg.svh"
module csw_startup_timer (
  input logic clk_sys,
  input logic rstn,
  input logic external_osc,
  csw_osc_if.startup_timer osc
);
  import csw_pkg::*;
  logic [2:0] sync;
  logic lvl;
  logic [10:0] cnt;
  logic fall;

  assign fall = lvl && !sync[1] && !sync[2];
  assign osc.ostDone = (cnt == `CSW_OST_CNT);

  always_ff @(posedge clk_sys)
  begin
    sync <= {sync[1:0], external_osc};
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      lvl <= 1'h0; // low, so a pin idling low gives no false fall
    else if (sync[1] == sync[2])
      lvl <= sync[1];
  end

  // reset doubles as power-on restart
  always_ff @(posedge clk_sys)
  begin
    if (!rstn || osc.ostRestart)
      cnt <= 11'h000;
    else if (fall && cnt != `CSW_OST_CNT)
      cnt <= cnt + 11'h001;
  end
endmodule // csw_startup_timer

// ===== hdl/csw_fail_detect.sv
/*
  Fail detector: latch set by monitored clock falls, cleared by sample clock.
  Assumes external_osc, secOsc and slowOsc are asynchronous pins.
*/
`timescale 1ns/1ps
`include "csw_cfg.svh"
module csw_fail_detect (
  input logic clk_sys,
  input logic rstn,
  input logic external_osc,
  input logic secOsc,
  input logic slowOsc,
  csw_osc_if.mon osc
);
  import csw_pkg::*;
  logic [2:0] monS;
  logic [2:0] slowS;
  logic monLvl, slowLvl, sampPrev, failLatch;
  logic monFall, slowRise, sampRise, sampFall;
  logic [5:0] divCnt;

  assign monFall = monLvl && !monS[1] && !monS[2];
  assign slowRise = !slowLvl && slowS[1] && slowS[2];
  assign sampRise = divCnt[`CSW_FS_MSB] && !sampPrev;
  assign sampFall = !divCnt[`CSW_FS_MSB] && sampPrev;

  always_ff @(posedge clk_sys)
  begin
    monS <= {monS[1:0], osc.monSec ? secOsc : external_osc};
    slowS <= {slowS[1:0], slowOsc};
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      monLvl <= 1'h0;
      slowLvl <= 1'h0;
    end
    else
    begin
      if (monS[1] == monS[2])
        monLvl <= monS[1];
      if (slowS[1] == slowS[2])
        slowLvl <= slowS[1];
    end
  end

  // sample clock is the top bit of a 64-step count
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      divCnt <= 6'h00;
      sampPrev <= 1'h0;
    end
    else
    begin
      if (slowRise)
        divCnt <= divCnt + 6'h01;
      sampPrev <= divCnt[`CSW_FS_MSB];
    end
  end

  // held set while idle so the first check spans a whole half period
  always_ff @(posedge clk_sys)
  begin
    if (!rstn || !osc.monEnable)
      failLatch <= 1'h1;
    else if (monFall)
      failLatch <= 1'h1;
    else if (sampRise)
      failLatch <= 1'h0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      osc.failPulse <= 1'h0;
    else
      osc.failPulse <= osc.monEnable && sampFall && !failLatch && !monFall;
  end
endmodule // csw_fail_detect

// ===== bench/csw_osc_model.sv
/*
  Oscillator side: external, secondary and slow internal clocks plus ready levels.
  Assumes a 1 ns time unit; extRun starts and stops the external clock,
  lockOk gives the PLL lock level.
*/
`timescale 1ns/1ps
module csw_osc_model (
  input wire logic extRun,
  input wire logic lockOk,
  output logic external_osc,
  output logic secOsc,
  output logic slowOsc,
  output logic fastReady,
  output logic secReady,
  output logic pllLock
);
  // ****************
  // clocks
  // ****************
  initial
  begin
    external_osc = 1'b0;
    secOsc = 1'b0;
    slowOsc = 1'b0;
  end
  // a stopped crystal holds its level: that is the failure modelled
  always #100 if (extRun) external_osc = ~external_osc;
  always #500 slowOsc = ~slowOsc;
  always #1000 secOsc = ~secOsc;
  // ****************
  // ready levels
  // ****************
  assign fastReady = 1'b1;
  assign secReady = 1'b1;
  assign pllLock = lockOk;
endmodule // csw_osc_model

// ===== bench/csw_clock_switch_test.sv
/*
  Self-checking bench of the clock switch: APB master, scenarios, verdict.
  Assumes the oscillator model drives the clock pins and ready levels.
*/
`timescale 1ns/1ps
`include "csw_cfg.svh"
module csw_clock_switch_test;
  import csw_pkg::*;
  // ****************
  // signals
  // ****************
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, err, external_osc, secOsc, slowOsc, fastReady, secReady, pllLock;
  logic failsafeEnable = 1'b1;
  logic dozeActive = 1'b0;
  logic sleepEnter = 1'b0;
  logic wakeUp = 1'b0;
  logic extRun = 1'b0;
  logic lockOk = 1'b1;
  csw_src_t sysSource;
  csw_div_t sysDivider;
  logic clkGateEn, cpuHalt, pllInputExt, sleeping, switchIrq, failIrq;
  int errors = 0;
  int num_checks = 0;
  int gc;
  always #25 clk_sys = ~clk_sys;
  csw_osc_model i_osc (.extRun(extRun), .lockOk(lockOk), .external_osc(external_osc), .secOsc(secOsc),
    .slowOsc(slowOsc), .fastReady(fastReady), .secReady(secReady), .pllLock(pllLock));
  csw_clock_switch i_dut (.clk_sys(clk_sys), .rstn(rstn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_osc(external_osc), .secOsc(secOsc),
    .slowOsc(slowOsc), .fastReady(fastReady), .secReady(secReady), .pllLock(pllLock),
    .failsafeEnable(failsafeEnable), .dozeActive(dozeActive), .sleepEnter(sleepEnter),
    .wakeUp(wakeUp), .sysSource(sysSource), .sysDivider(sysDivider),
    .clkGateEn(clkGateEn), .cpuHalt(cpuHalt), .pllInputExt(pllInputExt),
    .sleeping(sleeping), .switchIrq(switchIrq), .failIrq(failIrq));
  // ****************
  // helpers
  // ****************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  // counts cycles with the system clock gated
  task automatic gcnt(input int n);
    gc = 0;
    repeat (n)
    begin
      @(posedge clk_sys);
      if (clkGateEn === 1'b0) gc++;
    end
  endtask
  task automatic pulse(input logic s);
    @(posedge clk_sys);
    if (s) sleepEnter <= 1'b1;
    else wakeUp <= 1'b1;
    @(posedge clk_sys);
    sleepEnter <= 1'b0;
    wakeUp <= 1'b0;
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_reset;
    rdchk(`CSW_REQ_OFS, 32'h62, "req");
    rdchk(`CSW_CUR_OFS, 32'h62, "cur");
    rdchk(`CSW_CTL_OFS, 32'h10, "ctl");
    apb(1'b1, `CSW_IEN_OFS, 32'h03);
  endtask
  task automatic t_slow;
    apb(1'b1, `CSW_REQ_OFS, 32'h50);
    gcnt(12);
    chk("gate", `CSW_GATE_CYC, gc);
    chk("src", 32'h5, 32'(sysSource));
    rdchk(`CSW_CUR_OFS, 32'h50, "cur");
    rdchk(`CSW_CTL_OFS, 32'h10, "ctl");
    rdchk(`CSW_FLG_OFS, 32'h01, "flg");
    chk("swirq", 32'h1, 32'(switchIrq));
    apb(1'b1, `CSW_FLG_OFS, 32'h03);
    apb(1'b1, `CSW_REQ_OFS, 32'h31);
    rdchk(`CSW_REQ_OFS, 32'h50, "rsv");
    apb(1'b1, 8'h20, 32'h00);
    chk("slverr", 32'h1, 32'(err));
  endtask
  task automatic t_hold;
    apb(1'b1, `CSW_CTL_OFS, 32'h80);
    apb(1'b1, `CSW_REQ_OFS, 32'h64);
    gcnt(12);
    chk("held", 32'h0, gc);
    chk("oldsrc", 32'h5, 32'(sysSource));
    rdchk(`CSW_CTL_OFS, 32'h88, "ctl");
    apb(1'b1, `CSW_CTL_OFS, 32'h00);
    gcnt(12);
    chk("src", 32'h6, 32'(sysSource));
    chk("div", 32'h4, 32'(sysDivider));
    dozeActive <= 1'b1;
    apb(1'b1, `CSW_REQ_OFS, 32'h61);
    gcnt(12);
    chk("dozegate", 32'h1, gc);
    chk("divonly", 32'h1, 32'(sysDivider));
    dozeActive <= 1'b0;
  endtask
  // external start-up cannot finish while its clock is still
  task automatic t_sleep_fail;
    apb(1'b1, `CSW_FLG_OFS, 32'h03);
    apb(1'b1, `CSW_REQ_OFS, 32'h70);
    pulse(1'b1);
    gcnt(8);
    chk("sleep", 32'h1, 32'(sleeping));
    chk("nosw", 32'h6, 32'(sysSource));
    pulse(1'b0);
    gcnt(12);
    chk("wake", 32'h7, 32'(sysSource));
    rdchk(`CSW_FLG_OFS, 32'h01, "flg");
    extRun <= 1'b1;
    repeat (5000) @(posedge clk_sys);
    chk("ext", 32'h7, 32'(sysSource));
    extRun <= 1'b0;
    gc = 0;
    while (sysSource !== `CSW_SRC_FAST && gc < 3000)
    begin
      @(posedge clk_sys);
      gc++;
    end
    chk("fallback", 32'h6, 32'(sysSource));
    chk("failirq", 32'h1, 32'(failIrq));
    rdchk(`CSW_REQ_OFS, 32'h62, "req");
    apb(1'b0, `CSW_CTL_OFS, 32'h0);
    chk("fcond", 32'h1, rd & 32'h1);
    apb(1'b1, `CSW_FLG_OFS, 32'h03);
    apb(1'b1, `CSW_REQ_OFS, 32'h50);
    apb(1'b0, `CSW_CTL_OFS, 32'h0);
    chk("fclr", 32'h0, rd & 32'h1);
  endtask
  task automatic t_wake_hold;
    apb(1'b1, `CSW_CTL_OFS, 32'h80);
    apb(1'b1, `CSW_REQ_OFS, 32'h62);
    pulse(1'b1);
    pulse(1'b0);
    gcnt(12);
    chk("oldclk", 32'h5, 32'(sysSource));
    rdchk(`CSW_CTL_OFS, 32'h88, "again");
  endtask
  // pll input change with relock, then a relock that never locks
  task automatic t_pll;
    apb(1'b1, `CSW_CTL_OFS, 32'h00);
    apb(1'b1, `CSW_REQ_OFS, 32'h10);
    gcnt(12);
    chk("fpll", 32'h1, 32'(sysSource));
    extRun <= 1'b1;
    apb(1'b1, `CSW_REQ_OFS, 32'h20);
    gc = 0;
    repeat (6000)
    begin
      @(posedge clk_sys);
      if (cpuHalt === 1'b1) gc++;
    end
    chk("relock", 32'h3, gc);
    chk("epll", 32'h2, 32'(sysSource));
    chk("pllin", 32'h1, 32'(pllInputExt));
    lockOk <= 1'b0;
    apb(1'b1, `CSW_REQ_OFS, 32'h10);
    gcnt(60);
    chk("lockfail", 32'h6, 32'(sysSource));
    chk("lockirq", 32'h1, 32'(failIrq));
    apb(1'b1, `CSW_REQ_OFS, 32'h40);
    gcnt(1400);
    chk("sec", 32'h4, 32'(sysSource));
  endtask
  // ****************
  // sequence
  // ****************
  initial
  begin
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset();
    t_slow();
    t_hold();
    t_sleep_fail();
    t_wake_hold();
    t_pll();
    end_sim();
  end
  initial
  begin
    repeat (25000) @(posedge clk_sys);
    errors++;
    end_sim();
  end
endmodule // csw_clock_switch_test
